// file: rtl/psr_regs.svh
// Register offsets, fields, reset values and FIFO geometry for the shift register block
`ifndef PSR_REGS_SVH
`define PSR_REGS_SVH
// Register byte offsets
`define PSR_CTRL_OFF 12'h000
`define PSR_PAR_OFF 12'h004
`define PSR_STAT_OFF 12'h008
`define PSR_FIFO_OFF 12'h00C
`define PSR_FCNT_OFF 12'h010
// Control fields
`define PSR_CTRL_MODE_BIT 0
`define PSR_CTRL_J_BIT 1
`define PSR_CTRL_KN_BIT 2
`define PSR_CTRL_CLR_BIT 3
`define PSR_CTRL_STEP_BIT 4
`define PSR_CTRL_PUSH_BIT 5
// Reset values
`define PSR_CTRL_RST 8'h04
`define PSR_STAGE_RST 4'h0
// FIFO geometry
`define PSR_FIFO_DEPTH 32
`define PSR_FIFO_AW 5
`endif

// file: rtl/psr_pkg.sv
// Types shared by the shift register block
package psr_pkg;
  // Operating mode, shift when high
  typedef enum logic {
    PSR_LOAD = 1'b0,
    PSR_SHIFT = 1'b1
  } psr_mode_t;
  // Serial input pair of the first stage
  typedef struct packed {
    logic j;
    logic k_n;
  } psr_serial_t;
  // Snapshot of the four stages and the inverted last stage
  typedef struct packed {
    logic last_stage_out_n;
    logic [3:0] stages;
  } psr_snap_t;
endpackage

// file: rtl/psr_fifo.sv
// No logic here: the snapshot FIFO module is kept with the top level in psr_top.sv

// file: rtl/psr_top.sv
// Four-stage parallel-access shift register with APB control and snapshot FIFO
// What this block does
// RULE1: Exactly four stages, each with in/out.
// RULE2: Clear forces stages low, inverse high.
// RULE3: Mode low with data presented loads.
// RULE4: Load happens only on rising edge.
// RULE5: Load mode ignores serial J and K.
// RULE6: Mode high shifts one place per edge.
// RULE7: Data moves first stage toward last.
// RULE8: Shift fills first stage from J/K.
// RULE9: First stage acts as J-K flip-flop.
// RULE10: No edge, no change in outputs.
// RULE11: Extra output is inverse of last.
// RULE12: Clear async active low; resumes next edge.
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "psr_regs.svh"
module psr_top (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  input wire logic CLEAR_N,
  input wire logic SHIFT_NOT_LOAD_SELECT,
  input wire logic SERIAL_J,
  input wire logic SERIAL_K_N,
  input wire logic [3:0] PARALLEL_IN,
  input wire logic STEP,
  output logic FIRST_STAGE_OUT,
  output logic SECOND_STAGE_OUT,
  output logic THIRD_STAGE_OUT,
  output logic LAST_STAGE_OUT,
  output logic LAST_STAGE_OUT_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic SNAP_VALID,
  input wire logic SNAP_READY,
  output logic [4:0] SNAP_DATA
);
  // Stage storage, bit 0 is the first stage
  logic [3:0] stage_reg, stage_next;
  // Software control register
  logic [7:0] ctrl_reg, ctrl_next;
  logic [3:0] par_reg, par_next;
  // Read word and error flag, taken in the setup phase so they leave from flops
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;
  // Set once the answer to the current transfer has been captured
  logic arm_reg, arm_next;
  // Decoded step controls
  psr_pkg::psr_mode_t mode;
  psr_pkg::psr_serial_t ser;
  logic [3:0] par_sel;
  logic step_any, sw_step, sw_push;
  logic fifo_in_ready, fifo_out_valid;
  logic [4:0] fifo_out_data;
  logic [5:0] fifo_count;
  psr_pkg::psr_snap_t snap;
  // Access-edge write strobe and answer-capture strobe
  logic apb_wr, apb_capture;

  // First stage J-K rule: J low K_n high holds, J high K_n low toggles
  function automatic logic jk_next(input logic q, input psr_pkg::psr_serial_t s);
    logic r;
    r = q;
    case ({s.j, s.k_n})
      2'b01: r = q;
      2'b00: r = 1'b0;
      2'b11: r = 1'b1;
      2'b10: r = ~q;
      default: r = q;
    endcase
    return r;
  endfunction

  // Address match helper used by both read and write decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // Setup phase, or an access phase whose setup edge was frozen, captures the answer;
  // a write lands only at the access edge on which PREADY is high
  assign apb_capture = PSEL && (!PENABLE || !arm_reg);
  assign apb_wr = PSEL && PENABLE && PWRITE && PREADY;
  assign sw_step = apb_wr && hit(PADDR, `PSR_CTRL_OFF) && PWDATA[`PSR_CTRL_STEP_BIT];
  assign sw_push = apb_wr && hit(PADDR, `PSR_CTRL_OFF) && PWDATA[`PSR_CTRL_PUSH_BIT];

  // Pins and software control are merged: software override while CLR bit is set
  always_comb begin
    if (ctrl_reg[`PSR_CTRL_CLR_BIT]) begin
      mode = psr_pkg::psr_mode_t'(ctrl_reg[`PSR_CTRL_MODE_BIT]);
      ser.j = ctrl_reg[`PSR_CTRL_J_BIT];
      ser.k_n = ctrl_reg[`PSR_CTRL_KN_BIT];
      par_sel = par_reg;
    end else begin
      mode = psr_pkg::psr_mode_t'(SHIFT_NOT_LOAD_SELECT);
      ser.j = SERIAL_J;
      ser.k_n = SERIAL_K_N;
      par_sel = PARALLEL_IN;
    end
    // An edge acts only when a step is requested, else stages hold
    step_any = (STEP || sw_step) && CLK_EN;
  end

  // Stage next-value logic
  always_comb begin
    stage_next = stage_reg;
    // RULE10 hold without step
    if (step_any) begin
      case (mode)
        psr_pkg::PSR_LOAD: begin
          // RULE3 RULE5 broadside load, J/K ignored
          stage_next = par_sel;
        end
        psr_pkg::PSR_SHIFT: begin
          // RULE7 shift toward last stage
          stage_next[3:1] = stage_reg[2:0];
          // RULE8 RULE9 first stage from J/K
          stage_next[0] = jk_next(stage_reg[0], ser);
        end
        default: stage_next = stage_reg;
      endcase
    end
  end

  // Stage flops: clear is asynchronous and overrides everything
  // RULE2 RULE12 async clear of all stages
  always_ff @(posedge CORE_CLK or negedge RESETN or negedge CLEAR_N) begin
    if (!RESETN) begin
      stage_reg <= `PSR_STAGE_RST;
    end else if (!CLEAR_N) begin
      stage_reg <= `PSR_STAGE_RST;
    end else begin
      // RULE4 RULE6 update on rising edge only
      stage_reg <= stage_next;
    end
  end

  // RULE1 four outputs; RULE11 inverse of last stage
  assign FIRST_STAGE_OUT = stage_reg[0];
  assign SECOND_STAGE_OUT = stage_reg[1];
  assign THIRD_STAGE_OUT = stage_reg[2];
  assign LAST_STAGE_OUT = stage_reg[3];
  assign LAST_STAGE_OUT_N = ~stage_reg[3];

  // Snapshot pushed into FIFO on a push request and on every step; refused silently when full
  always_comb begin
    snap.last_stage_out_n = ~stage_reg[3];
    snap.stages = stage_reg;
  end

  // Register file next values; the read word and the error flag are taken
  // one edge ahead of the access edge, so status shows the setup-phase value
  always_comb begin
    ctrl_next = ctrl_reg;
    par_next = par_reg;
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    arm_next = 1'b0;
    if (apb_capture) begin
      arm_next = 1'b1;
      prdata_next = 32'h00000000;
      pslverr_next = 1'b0;
      if (hit(PADDR, `PSR_CTRL_OFF)) begin
        prdata_next = {24'h000000, ctrl_reg};
      end else if (hit(PADDR, `PSR_PAR_OFF)) begin
        prdata_next = {28'h0000000, par_reg};
      end else if (!PWRITE && hit(PADDR, `PSR_STAT_OFF)) begin
        // Status and count are read-only; a write there is an error
        prdata_next = {27'h0000000, snap};
      end else if (!PWRITE && hit(PADDR, `PSR_FCNT_OFF)) begin
        prdata_next = {26'h0000000, fifo_count};
      end else begin
        // Unmapped address answers with error and zero data
        pslverr_next = 1'b1;
      end
    end
    if (apb_wr) begin
      if (hit(PADDR, `PSR_CTRL_OFF)) begin
        // Step and push bits act once and are not stored
        ctrl_next = {4'h0, PWDATA[3:0]};
      end else if (hit(PADDR, `PSR_PAR_OFF)) begin
        par_next = PWDATA[3:0];
      end
    end
  end

  // Register file flops
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_reg <= `PSR_CTRL_RST;
      par_reg <= `PSR_STAGE_RST;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
      arm_reg <= 1'b0;
    end else if (CLK_EN) begin
      ctrl_reg <= ctrl_next;
      par_reg <= par_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
      arm_reg <= arm_next;
    end
  end

  // Zero wait states when the setup edge was enabled; a frozen setup edge costs
  // one extra cycle, so stale read data is never handed out
  always_comb begin
    PREADY = CLK_EN && arm_reg;
    PSLVERR = PSEL && PENABLE && pslverr_reg;
    PRDATA = prdata_reg;
  end

  // Snapshot FIFO; full FIFO drops the push request
  psr_fifo #(
    .WIDTH(5),
    .DEPTH(`PSR_FIFO_DEPTH),
    .AW(`PSR_FIFO_AW)
  ) u_fifo (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .ce(CLK_EN),
    .in_valid(sw_push || (step_any && fifo_in_ready)),
    .in_ready(fifo_in_ready),
    .in_data(snap),
    .out_valid(fifo_out_valid),
    .out_ready(SNAP_READY),
    .out_data(fifo_out_data),
    .count(fifo_count)
  );
  assign SNAP_VALID = fifo_out_valid;
  assign SNAP_DATA = fifo_out_data;
endmodule

// Snapshot FIFO with valid/ready on both sides; DEPTH must be a power of two
// so that the pointers can wrap without a compare
module psr_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] count
);
  // Storage array, one snapshot per word
  logic [WIDTH-1:0] mem [DEPTH];
  // Write and read pointers
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  // Occupancy is one bit wider than the pointers so full and empty differ
  logic [AW:0] cnt_reg, cnt_next;
  // Accepted transfers, already gated by the clock enable
  logic push, pop;
  // Handshakes; full and empty come straight from the count
  // A full buffer refuses a push even in a cycle that pops: simpler timing
  always_comb begin
    in_ready = (cnt_reg != (AW+1)'(DEPTH));
    out_valid = (cnt_reg != '0);
    push = in_valid && in_ready && ce;
    pop = out_valid && out_ready && ce;
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg;
    // A push and a pop in one cycle leave the count unchanged
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
    // Head word is shown while out_valid stands
    out_data = mem[rd_reg];
    count = cnt_reg;
  end
  // Pointer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
  // Array write; no reset so it maps to RAM
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end
endmodule

// file: tb/psr_snap_sink.sv
// Snapshot consumer that stands at the far side of the block
`timescale 1ns/1ps
module psr_snap_sink (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic valid,
  input wire logic [4:0] data,
  output logic ready,
  output int taken,
  output int bad
);
  // Ready follows the stall request one cycle late, like real logic would
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= 1'b0;
      taken <= 0;
      bad <= 0;
    end else begin
      ready <= !stall;
      if (valid && ready && (data[4] === data[3])) begin
        bad <= bad + 1;
      end
      if (valid && ready) begin
        taken <= taken + 1;
      end
    end
  end
endmodule

// file: tb/psr_top_assertions.sv
// Checker for the stage outputs of the shift register block
`timescale 1ns/1ps
module psr_top_assertions (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  input wire logic CLEAR_N,
  input wire logic SHIFT_NOT_LOAD_SELECT,
  input wire logic SERIAL_J,
  input wire logic SERIAL_K_N,
  input wire logic [3:0] PARALLEL_IN,
  input wire logic STEP,
  input wire logic PSEL,
  input wire logic FIRST_STAGE_OUT,
  input wire logic SECOND_STAGE_OUT,
  input wire logic THIRD_STAGE_OUT,
  input wire logic LAST_STAGE_OUT,
  input wire logic LAST_STAGE_OUT_N
);
  // Stage vector, bit0 is the first stage
  wire [3:0] s = {LAST_STAGE_OUT, THIRD_STAGE_OUT, SECOND_STAGE_OUT, FIRST_STAGE_OUT};
  // A pin step; bus cycles are left out since they may step too
  wire go = CLK_EN && STEP && CLEAR_N && !PSEL;
  wire m = SHIFT_NOT_LOAD_SELECT;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  chk_inverse_out: assert property (LAST_STAGE_OUT_N == !LAST_STAGE_OUT)
    else $error("inverse output wrong");
  chk_clear_zero: assert property (!CLEAR_N |-> s == 4'h0 && LAST_STAGE_OUT_N)
    else $error("clear did not empty stages");
  chk_load_copy: assert property (go && !m ##1 CLEAR_N |-> s[3:1] == $past(PARALLEL_IN[3:1]))
    else $error("load wrong");
  chk_load_no_serial: assert property (go && !m ##1 CLEAR_N |-> s[0] == $past(PARALLEL_IN[0]))
    else $error("serial entered on load");
  chk_shift_move: assert property (go && m ##1 CLEAR_N |-> s[3:1] == $past(s[2:0]))
    else $error("shift wrong");
  chk_jk_first: assert property (go && m ##1 CLEAR_N |->
    s[0] == ($past(SERIAL_J) & !$past(s[0]) | $past(SERIAL_K_N) & $past(s[0])))
    else $error("first stage wrong");
  chk_hold_idle: assert property (!(CLK_EN && STEP) && !PSEL ##1 CLEAR_N |-> $stable(s))
    else $error("stages moved without step");
  chk_clear_resume: assert property ($rose(CLEAR_N) ##1 go && !m |=> s == $past(PARALLEL_IN))
    else $error("no load after clear");
endmodule
bind psr_top psr_top_assertions i_chk (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .CLK_EN(CLK_EN),
  .CLEAR_N(CLEAR_N), .SHIFT_NOT_LOAD_SELECT(SHIFT_NOT_LOAD_SELECT), .SERIAL_J(SERIAL_J),
  .SERIAL_K_N(SERIAL_K_N), .PARALLEL_IN(PARALLEL_IN), .STEP(STEP), .PSEL(PSEL),
  .FIRST_STAGE_OUT(FIRST_STAGE_OUT), .SECOND_STAGE_OUT(SECOND_STAGE_OUT),
  .THIRD_STAGE_OUT(THIRD_STAGE_OUT), .LAST_STAGE_OUT(LAST_STAGE_OUT),
  .LAST_STAGE_OUT_N(LAST_STAGE_OUT_N));

// file: tb/psr_top_bench.sv
// Self-checking bench for the shift register block
`timescale 1ns/1ps
`include "psr_regs.svh"
module psr_top_bench;
  logic CORE_CLK = 0, RESETN = 0, CLK_EN = 1, CLEAR_N = 1, STEP = 0;
  logic SHIFT_NOT_LOAD_SELECT = 0, SERIAL_J = 0, SERIAL_K_N = 1;
  logic [3:0] PARALLEL_IN = 4'h0, e;
  logic PSEL = 0, PENABLE = 0, PWRITE = 0, stall = 1, err;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic PREADY, PSLVERR, SNAP_VALID, SNAP_READY, LAST_STAGE_OUT_N;
  logic FIRST_STAGE_OUT, SECOND_STAGE_OUT, THIRD_STAGE_OUT, LAST_STAGE_OUT;
  logic [4:0] SNAP_DATA;
  int bad_count = 0, n_checks = 0, taken, sbad;
  wire [3:0] q = {LAST_STAGE_OUT, THIRD_STAGE_OUT, SECOND_STAGE_OUT, FIRST_STAGE_OUT};
  psr_top i_psr_top (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .CLK_EN(CLK_EN),
    .CLEAR_N(CLEAR_N), .SHIFT_NOT_LOAD_SELECT(SHIFT_NOT_LOAD_SELECT), .SERIAL_J(SERIAL_J),
    .SERIAL_K_N(SERIAL_K_N), .PARALLEL_IN(PARALLEL_IN), .STEP(STEP),
    .FIRST_STAGE_OUT(FIRST_STAGE_OUT), .SECOND_STAGE_OUT(SECOND_STAGE_OUT),
    .THIRD_STAGE_OUT(THIRD_STAGE_OUT), .LAST_STAGE_OUT(LAST_STAGE_OUT),
    .LAST_STAGE_OUT_N(LAST_STAGE_OUT_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SNAP_VALID(SNAP_VALID), .SNAP_READY(SNAP_READY), .SNAP_DATA(SNAP_DATA));
  psr_snap_sink i_psr_snap_sink (.clk(CORE_CLK), .rst_n(RESETN), .stall(stall),
    .valid(SNAP_VALID), .data(SNAP_DATA), .ready(SNAP_READY), .taken(taken), .bad(sbad));
  // Free-running core clock
  always #12.5 CORE_CLK = ~CORE_CLK;
  // Compare and count
  task automatic chk(string nm, logic [31:0] x, logic [31:0] v);
    n_checks++;
    if (v !== x) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", nm, x, v);
    end
  endtask
  // One APB transfer; waits on pready rather than assuming zero wait
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge CORE_CLK);
    PSEL <= 1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1;
    do @(posedge CORE_CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  // One pin step with mode, serial pair and parallel data held steady
  task automatic step(logic m, logic j, logic kn, logic [3:0] d);
    @(posedge CORE_CLK);
    SHIFT_NOT_LOAD_SELECT <= m;
    SERIAL_J <= j;
    SERIAL_K_N <= kn;
    PARALLEL_IN <= d;
    STEP <= 1;
    @(posedge CORE_CLK);
    STEP <= 0;
    #1;
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog, far beyond the fewer than two hundred cycles needed
  initial begin
    #100us;
    bad_count++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge CORE_CLK);
    RESETN <= 1;
    #1;
    chk("reset", 4'h0, q);
    chk("inv", 1, LAST_STAGE_OUT_N);
    apb(0, `PSR_CTRL_OFF, 0);
    chk("ctrl", 32'h04, rd);
    apb(0, 12'h040, 0);
    chk("unmapped", 1, err);
    apb(1, `PSR_STAT_OFF, 0);
    chk("ro", 1, err);
    // Toggle request on J/K must be ignored during load
    step(0, 1, 0, 4'hA);
    chk("load", 4'hA, q);
    PARALLEL_IN <= 4'h5;
    repeat (3) @(posedge CORE_CLK);
    #1 chk("idle", 4'hA, q);
    CLK_EN <= 0;
    step(0, 0, 1, 4'h3);
    chk("frozen", 4'hA, q);
    CLK_EN <= 1;
    e = 4'hA;
    // Every J/K pair, twice; both toggles start from a low first stage
    for (int i = 0; i < 8; i++) begin
      step(1, i[1], i[0], 4'hF);
      e = {e[2:0], (i[1] & !e[0]) | (i[0] & e[0])};
      chk("shift", e, q);
      chk("inv", !e[3], LAST_STAGE_OUT_N);
    end
    CLEAR_N <= 0;
    #3 chk("clear", 5'h10, {LAST_STAGE_OUT_N, q});
    step(0, 0, 1, 4'hF);
    chk("clear held", 4'h0, q);
    CLEAR_N <= 1;
    step(0, 0, 1, 4'h6);
    chk("resume", 4'h6, q);
    // Software path: override the pins, load PAR by a bus step, then toggle-shift
    apb(1, `PSR_PAR_OFF, 32'h9);
    apb(1, `PSR_CTRL_OFF, 32'h0C);
    apb(1, `PSR_CTRL_OFF, 32'h1C);
    #1 chk("sw load", 4'h9, q);
    apb(1, `PSR_CTRL_OFF, 32'h0B);
    apb(1, `PSR_CTRL_OFF, 32'h1B);
    #1 chk("sw toggle", 4'h2, q);
    apb(0, `PSR_CTRL_OFF, 0);
    chk("ctrl kept", 32'h0B, rd);
    // Give the pins back and push one snapshot by software
    apb(1, `PSR_CTRL_OFF, 32'h24);
    chk("push ok", 0, err);
    // Overfill the snapshot buffer while the sink stalls
    repeat (34) step(1, 0, 1, 4'h0);
    apb(0, `PSR_FCNT_OFF, 0);
    chk("full", `PSR_FIFO_DEPTH, rd);
    stall <= 0;
    repeat (40) @(posedge CORE_CLK);
    apb(0, `PSR_FCNT_OFF, 0);
    chk("empty", 0, rd);
    chk("taken", `PSR_FIFO_DEPTH, taken);
    chk("snap inv", 0, sbad);
    complete_run;
  end
endmodule
